// ### design/tec_tap_events.sv
/*
  Tap event configuration and status block: APB register file holding tap configuration, latched tap
  source, per-axis thresholds and latency, plus interrupt status, enable and clear registers.
  Assumes the tap detection datapath runs on pclk and supplies one-cycle tap start, end and polarity
  strobes per axis and a one-cycle sample tick at the output data rate.
*/
//
// Notes on behaviour
// - Configuration bits 0, 2, 4 enable single-tap flags on X, Y, Z.
// - Configuration bits 1, 3, 5 enable double-tap flags on X, Y, Z.
// - Each flag enable is 0 after reset, disabling its event; 1 enables it.
// - With abort bit 7 clear, double-tap detection continues through taps in latency.
// - With abort set, a tap starting and ending in latency suspends double detection.
// - With latch enable bit 6 set, flags stay in the source until it is read.
// - A source flag is set only when its axis and event type are enabled.
// - Source bit 7 reads 1 once any enabled tap event was generated, else 0.
// - Source bits 6, 5, 4 report Z, Y, X tap events.
// - Source bit 3 is 0 for single tap and 1 for double tap.
// - Source bits 2, 1, 0 give Z, Y, X polarity, 1 meaning negative.
// - Once active is set under latch enable, all other source bits freeze.
// - Reading the source register clears all its bits.
// - Reading the source register also drops the tap interrupt request.
// - Separate X, Y, Z thresholds are held and start detection per axis.
// - X threshold is seven bits 6..0, reset zero, bit 7 reads 0.
// - A threshold is unsigned seven bits; only 1 to 127 arms detection.
// - With abort bit 7 clear, taps arriving during the latency interval after a first tap are ignored.
`timescale 1ns/10ps
`default_nettype none
module tec_tap_events (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tec_pkg::TEC_AW-1:0] paddr,
  input wire logic [tec_pkg::TEC_DW-1:0] pwdata,
  output logic [tec_pkg::TEC_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_tick,
  input wire logic [tec_pkg::TEC_NAXIS-1:0] tap_start,
  input wire logic [tec_pkg::TEC_NAXIS-1:0] tap_end,
  input wire logic [tec_pkg::TEC_NAXIS-1:0] tap_negative,
  output logic [tec_pkg::TEC_THR_W-1:0] x_tap_threshold,
  output logic [tec_pkg::TEC_THR_W-1:0] y_tap_threshold,
  output logic [tec_pkg::TEC_THR_W-1:0] z_tap_threshold,
  output logic [tec_pkg::TEC_NAXIS-1:0] axis_armed,
  output logic tap_irq,
  output logic irq
);

  logic [7:0] cfg_q;
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [tec_pkg::TEC_THR_W-1:0] thr_x_q;
  logic [tec_pkg::TEC_THR_W-1:0] thr_y_q;
  logic [tec_pkg::TEC_THR_W-1:0] thr_z_q;
  logic [tec_pkg::TEC_LAT_W-1:0] latency_q;
  logic [tec_pkg::TEC_IRQ_W-1:0] ist_q;
  logic [tec_pkg::TEC_IRQ_W-1:0] ist_d;
  logic [tec_pkg::TEC_IRQ_W-1:0] ien_q;
  logic [tec_pkg::TEC_NAXIS-1:0] armed_q;
  logic [tec_pkg::TEC_NAXIS-1:0] single_evt;
  logic [tec_pkg::TEC_NAXIS-1:0] double_evt;
  logic [tec_pkg::TEC_NAXIS-1:0] single_en;
  logic [tec_pkg::TEC_NAXIS-1:0] double_en;
  logic [tec_pkg::TEC_NAXIS-1:0] single_hit;
  logic [tec_pkg::TEC_NAXIS-1:0] double_hit;
  logic [tec_pkg::TEC_NAXIS-1:0] axis_hit;
  logic any_hit;
  logic frozen;
  logic setup;
  logic access_done;
  logic wr_en;
  logic rd_src;
  logic addr_hit;
  logic [tec_pkg::TEC_DW-1:0] rd_mux;
  logic pready_q;
  logic pslverr_q;
  logic [tec_pkg::TEC_DW-1:0] prdata_q;
  logic irq_q;

  // Flag enables, pulled out of the configuration register per axis.
  assign single_en = {cfg_q[tec_pkg::TEC_CFG_SINGLE_Z], cfg_q[tec_pkg::TEC_CFG_SINGLE_Y],
                      cfg_q[tec_pkg::TEC_CFG_SINGLE_X]};
  assign double_en = {cfg_q[tec_pkg::TEC_CFG_DOUBLE_Z], cfg_q[tec_pkg::TEC_CFG_DOUBLE_Y],
                      cfg_q[tec_pkg::TEC_CFG_DOUBLE_X]};

  genvar ax;
  generate
    for (ax = 0; ax < tec_pkg::TEC_NAXIS; ax++) begin : g_axis
      tec_axis_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .sample_tick(sample_tick),
        .armed(armed_q[ax]),
        .tap_start(tap_start[ax]),
        .tap_end(tap_end[ax]),
        .dbl_abort(cfg_q[tec_pkg::TEC_CFG_DOUBLE_ABORT]),
        .latency(latency_q),
        .single_evt_q(single_evt[ax]),
        .double_evt_q(double_evt[ax])
      );
    end
  endgenerate

  // A disabled event type never reaches the source register.
  assign single_hit = single_evt & single_en;
  assign double_hit = double_evt & double_en;
  assign axis_hit = single_hit | double_hit;
  assign any_hit = |axis_hit;
  assign frozen = cfg_q[tec_pkg::TEC_CFG_EVENT_LATCH] && src_q[tec_pkg::TEC_SRC_ACTIVE];

  // APB: setup cycle registers the answer, access phase completes in one cycle.
  assign setup = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign wr_en = access_done && pwrite && !pslverr_q;
  assign rd_src = access_done && !pwrite && !pslverr_q && (paddr == tec_pkg::TEC_ADDR_SOURCE);

  always_comb begin
    rd_mux = '0;
    addr_hit = 1'b1;
    case (paddr)
      tec_pkg::TEC_ADDR_CONFIG: rd_mux[7:0] = cfg_q;
      tec_pkg::TEC_ADDR_SOURCE: rd_mux[7:0] = src_q;
      tec_pkg::TEC_ADDR_THR_X: rd_mux[tec_pkg::TEC_THR_W-1:0] = thr_x_q;
      tec_pkg::TEC_ADDR_THR_Y: rd_mux[tec_pkg::TEC_THR_W-1:0] = thr_y_q;
      tec_pkg::TEC_ADDR_THR_Z: rd_mux[tec_pkg::TEC_THR_W-1:0] = thr_z_q;
      tec_pkg::TEC_ADDR_LATENCY: rd_mux[tec_pkg::TEC_LAT_W-1:0] = latency_q;
      tec_pkg::TEC_ADDR_IRQ_STATUS: rd_mux[tec_pkg::TEC_IRQ_W-1:0] = ist_q;
      tec_pkg::TEC_ADDR_IRQ_ENABLE: rd_mux[tec_pkg::TEC_IRQ_W-1:0] = ien_q;
      tec_pkg::TEC_ADDR_IRQ_CLEAR: rd_mux = '0;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !addr_hit;
        prdata_q <= rd_mux;
      end else if (access_done) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= tec_pkg::TEC_CONFIG_RST;
      thr_x_q <= tec_pkg::TEC_THR_RST;
      thr_y_q <= tec_pkg::TEC_THR_RST;
      thr_z_q <= tec_pkg::TEC_THR_RST;
      latency_q <= tec_pkg::TEC_LAT_RST;
      ien_q <= tec_pkg::TEC_IRQ_RST;
    end else if (wr_en) begin
      case (paddr)
        tec_pkg::TEC_ADDR_CONFIG: cfg_q <= pwdata[7:0];
        tec_pkg::TEC_ADDR_THR_X: thr_x_q <= pwdata[tec_pkg::TEC_THR_W-1:0];
        tec_pkg::TEC_ADDR_THR_Y: thr_y_q <= pwdata[tec_pkg::TEC_THR_W-1:0];
        tec_pkg::TEC_ADDR_THR_Z: thr_z_q <= pwdata[tec_pkg::TEC_THR_W-1:0];
        tec_pkg::TEC_ADDR_LATENCY: latency_q <= pwdata[tec_pkg::TEC_LAT_W-1:0];
        tec_pkg::TEC_ADDR_IRQ_ENABLE: ien_q <= pwdata[tec_pkg::TEC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Zero is outside the usable threshold range, so an axis left at zero never starts a tap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= '0;
    end else begin
      armed_q <= {thr_z_q != '0, thr_y_q != '0, thr_x_q != '0};
    end
  end

  // Unless latch enable has frozen the source, a new event in the cycle of a source read is kept: the event wins over the clear.
  always_comb begin
    src_d = src_q;
    if (any_hit && !frozen) begin
      src_d[tec_pkg::TEC_SRC_ACTIVE] = 1'b1;
      src_d[tec_pkg::TEC_SRC_AXIS_LSB +: tec_pkg::TEC_NAXIS] = axis_hit;
      src_d[tec_pkg::TEC_SRC_DOUBLE] = |double_hit;
      src_d[tec_pkg::TEC_SRC_POL_LSB +: tec_pkg::TEC_NAXIS] = tap_negative & axis_hit;
    end else if (rd_src && (src_q == prdata_q[7:0])) begin
      // A load at the setup edge is newer than the data being returned, so that read must not wipe it.
      src_d = tec_pkg::TEC_SOURCE_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= tec_pkg::TEC_SOURCE_RST;
    end else begin
      src_q <= src_d;
    end
  end

  always_comb begin
    ist_d = ist_q;
    if (wr_en && (paddr == tec_pkg::TEC_ADDR_IRQ_CLEAR)) begin
      ist_d = ist_q & ~pwdata[tec_pkg::TEC_IRQ_W-1:0];
    end
    if (|single_hit) begin
      ist_d[tec_pkg::TEC_IRQ_SINGLE] = 1'b1;
    end
    if (|double_hit) begin
      ist_d[tec_pkg::TEC_IRQ_DOUBLE] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= tec_pkg::TEC_IRQ_RST;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq_q <= |(ist_d & ien_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign x_tap_threshold = thr_x_q;
  assign y_tap_threshold = thr_y_q;
  assign z_tap_threshold = thr_z_q;
  assign axis_armed = armed_q;
  assign tap_irq = src_q[tec_pkg::TEC_SRC_ACTIVE];
  assign irq = irq_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cfg_write_lands: assert property (
    wr_en && (paddr == tec_pkg::TEC_ADDR_CONFIG) |=> cfg_q == $past(pwdata[7:0]))
    else $error("configuration write not stored");

  a_flag_needs_enable: assert property (
    $rose(src_q[tec_pkg::TEC_SRC_AXIS_LSB]) |-> $past(single_en[0] || double_en[0]))
    else $error("X axis flag set without an enable");

  a_active_reflects: assert property (
    (src_q != '0) |-> src_q[tec_pkg::TEC_SRC_ACTIVE])
    else $error("source bits set without the active flag");

  a_axis_loaded: assert property (
    any_hit && !frozen |=> src_q[tec_pkg::TEC_SRC_AXIS_LSB +: tec_pkg::TEC_NAXIS] == $past(axis_hit))
    else $error("axis flags do not match the event");

  a_double_kind: assert property (
    any_hit && !frozen |=> src_q[tec_pkg::TEC_SRC_DOUBLE] == $past(|double_hit))
    else $error("double tap flag wrong");

  a_polarity_loaded: assert property (
    any_hit && !frozen |=> src_q[tec_pkg::TEC_SRC_POL_LSB +: tec_pkg::TEC_NAXIS] == $past(tap_negative & axis_hit))
    else $error("polarity bits wrong");

  a_latched_freeze: assert property (
    frozen && !rd_src |=> $stable(src_q))
    else $error("latched source changed before a read");

  a_read_clears: assert property (
    rd_src && (src_q == prdata_q[7:0]) && !(any_hit && !frozen) |=> (src_q == '0) && !tap_irq)
    else $error("source read did not clear");

  a_latch_holds: assert property (
    cfg_q[tec_pkg::TEC_CFG_EVENT_LATCH] && tap_irq && !rd_src |=> tap_irq)
    else $error("latched event lost without a read");

  a_thr_top_zero: assert property (
    setup && (paddr == tec_pkg::TEC_ADDR_THR_X) |=> prdata_q[tec_pkg::TEC_DW-1:tec_pkg::TEC_THR_W] == '0)
    else $error("threshold upper bits not zero");

  a_zero_unarmed: assert property (
    (thr_x_q == '0) |=> !armed_q[0])
    else $error("zero threshold armed the X axis");

  a_single_ack: assert property (
    setup |=> pready_q ##1 !pready_q)
    else $error("APB answer not a single cycle");

  a_flag_y_enable: assert property (
    $rose(src_q[tec_pkg::TEC_SRC_AXIS_LSB + 1]) |-> $past(single_en[1] || double_en[1]))
    else $error("Y axis flag set without an enable");

  a_flag_z_enable: assert property (
    $rose(src_q[tec_pkg::TEC_SRC_AXIS_LSB + 2]) |-> $past(single_en[2] || double_en[2]))
    else $error("Z axis flag set without an enable");

  a_double_needs_en: assert property (
    $rose(src_q[tec_pkg::TEC_SRC_DOUBLE]) |-> $past(|double_en))
    else $error("double tap flag set without a double enable");

  a_no_hit_quiet: assert property (
    !any_hit |=> !$rose(src_q[tec_pkg::TEC_SRC_ACTIVE]))
    else $error("active flag rose without an enabled event");

  a_read_keeps_new: assert property (
    rd_src && (src_q != prdata_q[7:0]) |=> src_q[tec_pkg::TEC_SRC_ACTIVE])
    else $error("event loaded during a source read was lost");

  a_irq_follows: assert property (
    $stable(ien_q) |-> irq_q == |(ist_q & ien_q))
    else $error("interrupt line does not follow enabled status");

  a_single_sets_status: assert property (
    (|single_hit) |=> ist_q[tec_pkg::TEC_IRQ_SINGLE])
    else $error("single tap did not set interrupt status");

  a_double_sets_status: assert property (
    (|double_hit) |=> ist_q[tec_pkg::TEC_IRQ_DOUBLE])
    else $error("double tap did not set interrupt status");

  a_status_clears: assert property (
    wr_en && (paddr == tec_pkg::TEC_ADDR_IRQ_CLEAR) && pwdata[tec_pkg::TEC_IRQ_SINGLE] && !(|single_hit)
      |=> !ist_q[tec_pkg::TEC_IRQ_SINGLE])
    else $error("interrupt status not cleared by a clear write");

  a_unmapped_error: assert property (
    setup && !addr_hit |=> pslverr_q)
    else $error("unmapped address answered without an error");

  a_error_no_write: assert property (
    access_done && pslverr_q |=> $stable(cfg_q) && $stable(ien_q))
    else $error("erroneous access changed a register");

  a_x_armed: assert property (
    (thr_x_q != '0) |=> armed_q[0])
    else $error("nonzero threshold did not arm the X axis");

  a_y_zero_unarmed: assert property (
    (thr_y_q == '0) |=> !armed_q[1])
    else $error("zero threshold armed the Y axis");

  a_z_zero_unarmed: assert property (
    (thr_z_q == '0) |=> !armed_q[2])
    else $error("zero threshold armed the Z axis");

endmodule : tec_tap_events
`default_nettype wire

// ### design/tec_pkg.sv
/*
  Package for the tap event configuration and status block: register indices, byte addresses, field positions,
  reset values and the per-axis sequencer states.
  Assumes a 32-bit APB bus whose byte address is four times the register index.
*/
package tec_pkg;

  localparam int unsigned TEC_AW = 12;
  localparam int unsigned TEC_DW = 32;
  localparam int unsigned TEC_NAXIS = 3;

  // Register indices; the byte address is the index times four.
  localparam logic [7:0] TEC_IDX_CONFIG = 8'h21;
  localparam logic [7:0] TEC_IDX_SOURCE = 8'h22;
  localparam logic [7:0] TEC_IDX_THR_X = 8'h23;
  localparam logic [7:0] TEC_IDX_THR_Y = 8'h24;
  localparam logic [7:0] TEC_IDX_THR_Z = 8'h25;
  localparam logic [7:0] TEC_IDX_LATENCY = 8'h27;
  localparam logic [7:0] TEC_IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] TEC_IDX_IRQ_ENABLE = 8'h31;
  localparam logic [7:0] TEC_IDX_IRQ_CLEAR = 8'h32;

  localparam logic [TEC_AW-1:0] TEC_ADDR_CONFIG = {2'h0, TEC_IDX_CONFIG, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_SOURCE = {2'h0, TEC_IDX_SOURCE, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_THR_X = {2'h0, TEC_IDX_THR_X, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_THR_Y = {2'h0, TEC_IDX_THR_Y, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_THR_Z = {2'h0, TEC_IDX_THR_Z, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_LATENCY = {2'h0, TEC_IDX_LATENCY, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_IRQ_STATUS = {2'h0, TEC_IDX_IRQ_STATUS, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_IRQ_ENABLE = {2'h0, TEC_IDX_IRQ_ENABLE, 2'h0};
  localparam logic [TEC_AW-1:0] TEC_ADDR_IRQ_CLEAR = {2'h0, TEC_IDX_IRQ_CLEAR, 2'h0};

  // Configuration fields: single-tap enable of axis a at 2a, double-tap enable at 2a+1.
  localparam int unsigned TEC_CFG_SINGLE_X = 0;
  localparam int unsigned TEC_CFG_DOUBLE_X = 1;
  localparam int unsigned TEC_CFG_SINGLE_Y = 2;
  localparam int unsigned TEC_CFG_DOUBLE_Y = 3;
  localparam int unsigned TEC_CFG_SINGLE_Z = 4;
  localparam int unsigned TEC_CFG_DOUBLE_Z = 5;
  localparam int unsigned TEC_CFG_EVENT_LATCH = 6;
  localparam int unsigned TEC_CFG_DOUBLE_ABORT = 7;

  // Source fields: polarity of axis a at a, double flag at 3, axis flag of axis a at 4+a, active at 7.
  localparam int unsigned TEC_SRC_POL_LSB = 0;
  localparam int unsigned TEC_SRC_DOUBLE = 3;
  localparam int unsigned TEC_SRC_AXIS_LSB = 4;
  localparam int unsigned TEC_SRC_ACTIVE = 7;

  localparam int unsigned TEC_THR_W = 7;
  localparam int unsigned TEC_LAT_W = 8;

  // Interrupt status, enable and clear share this layout.
  localparam int unsigned TEC_IRQ_SINGLE = 0;
  localparam int unsigned TEC_IRQ_DOUBLE = 1;
  localparam int unsigned TEC_IRQ_W = 2;

  localparam logic [7:0] TEC_CONFIG_RST = 8'h00;
  localparam logic [7:0] TEC_SOURCE_RST = 8'h00;
  localparam logic [TEC_THR_W-1:0] TEC_THR_RST = 7'h00;
  localparam logic [TEC_LAT_W-1:0] TEC_LAT_RST = 8'h00;
  localparam logic [TEC_IRQ_W-1:0] TEC_IRQ_RST = 2'h0;

  typedef enum logic [1:0] {
    TEC_AX_IDLE,
    TEC_AX_LATENCY,
    TEC_AX_SECOND
  } tec_axis_state_t;

endpackage : tec_pkg

// ### design/tec_axis_seq.sv
/*
  Per-axis tap sequencer: turns tap start and end strobes into single-tap and double-tap event pulses,
  ignoring taps during the latency window and optionally aborting a double tap.
  Assumes tap strobes and the sample tick are one-cycle pulses from logic on pclk.
*/
`timescale 1ns/10ps
`default_nettype none
module tec_axis_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  input wire logic armed,
  input wire logic tap_start,
  input wire logic tap_end,
  input wire logic dbl_abort,
  input wire logic [tec_pkg::TEC_LAT_W-1:0] latency,
  output logic single_evt_q,
  output logic double_evt_q
);

  tec_pkg::tec_axis_state_t state_q;
  logic [tec_pkg::TEC_LAT_W-1:0] cnt_q;
  logic started_q;
  logic abort_now;

  assign abort_now = dbl_abort && started_q && tap_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tec_pkg::TEC_AX_IDLE;
      cnt_q <= tec_pkg::TEC_LAT_RST;
      started_q <= 1'b0;
      single_evt_q <= 1'b0;
      double_evt_q <= 1'b0;
    end else begin
      single_evt_q <= 1'b0;
      double_evt_q <= 1'b0;
      case (state_q)
        tec_pkg::TEC_AX_IDLE: begin
          if (armed && tap_end) begin
            single_evt_q <= 1'b1;
            state_q <= tec_pkg::TEC_AX_LATENCY;
            cnt_q <= latency;
            started_q <= 1'b0;
          end
        end
        tec_pkg::TEC_AX_LATENCY: begin
          // Taps inside the window are ignored; only a completed tap under abort ends the sequence.
          if (tap_start) begin
            started_q <= 1'b1;
          end
          if (abort_now) begin
            state_q <= tec_pkg::TEC_AX_IDLE;
          end else if (sample_tick) begin
            if (cnt_q == '0) begin
              state_q <= tec_pkg::TEC_AX_SECOND;
              cnt_q <= latency;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
        tec_pkg::TEC_AX_SECOND: begin
          if (armed && tap_end) begin
            double_evt_q <= 1'b1;
            state_q <= tec_pkg::TEC_AX_IDLE;
          end else if (sample_tick) begin
            if (cnt_q == '0) begin
              state_q <= tec_pkg::TEC_AX_IDLE;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
        default: begin
          state_q <= tec_pkg::TEC_AX_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_abort_ends_seq: assert property (
    (state_q == tec_pkg::TEC_AX_LATENCY) && abort_now |=> (state_q == tec_pkg::TEC_AX_IDLE) && !double_evt_q)
    else $error("double tap abort did not return to idle");

  a_latency_continues: assert property (
    (state_q == tec_pkg::TEC_AX_LATENCY) && !dbl_abort && !sample_tick |=> state_q == tec_pkg::TEC_AX_LATENCY)
    else $error("latency window left without a tick while abort is off");

  a_latency_ignores: assert property (
    state_q == tec_pkg::TEC_AX_LATENCY |=> !single_evt_q && !double_evt_q)
    else $error("event produced during latency window");

endmodule : tec_axis_seq
`default_nettype wire

// ### test/tec_tap_events_tb.sv
/*
  Self-checking testbench for the tap event configuration and status block, driven over APB.
  Assumes the design answers each APB access with a one-cycle pready and updates the source
  register two edges after a tap end strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_tick = 1'b0;
  logic [2:0] tap_start = 3'h0;
  logic [2:0] tap_end = 3'h0;
  logic [2:0] tap_negative = 3'h0;
  logic [6:0] x_tap_threshold;
  logic [6:0] y_tap_threshold;
  logic [6:0] z_tap_threshold;
  logic [2:0] axis_armed;
  logic tap_irq;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int n_compared = 0;

  tec_tap_events uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(sample_tick), .tap_start(tap_start), .tap_end(tap_end), .tap_negative(tap_negative),
    .x_tap_threshold(x_tap_threshold), .y_tap_threshold(y_tap_threshold), .z_tap_threshold(z_tap_threshold),
    .axis_armed(axis_armed), .tap_irq(tap_irq), .irq(irq));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task results;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request stands until the rising edge at which pready is sampled high; data are taken at that edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, 32'h0);
  endtask : rdchk

  task sync;
    repeat (3) @(negedge pclk);
  endtask : sync

  task tap(input int a, input logic neg);
    @(posedge pclk);
    tap_start <= 3'h1 << a;
    @(posedge pclk);
    tap_start <= 3'h0;
    tap_end <= 3'h1 << a;
    tap_negative <= {2'h0, neg} << a;
    @(posedge pclk);
    tap_end <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask : tap

  task tick;
    @(posedge pclk);
    sample_tick <= 1'b1;
    @(posedge pclk);
    sample_tick <= 1'b0;
  endtask : tick

  // Enough ticks to run out both the latency and the second-tap window with latency set to 1.
  task settle;
    repeat (8) tick();
  endtask : settle

  task t_reset;
    rdchk(tec_pkg::TEC_ADDR_CONFIG, 32'h0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    rdchk(tec_pkg::TEC_ADDR_THR_X, 32'h0);
    rdchk(tec_pkg::TEC_ADDR_IRQ_STATUS, 32'h0);
    chk({31'h0, tap_irq}, 32'h0);
  endtask : t_reset

  task t_regs;
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'hFF);
    rdchk(tec_pkg::TEC_ADDR_CONFIG, 32'hFF);
    wr(tec_pkg::TEC_ADDR_THR_X, 32'hFFFF_FFFF);
    rdchk(tec_pkg::TEC_ADDR_THR_X, 32'h7F);
    chk({25'h0, x_tap_threshold}, 32'h7F);
    wr(tec_pkg::TEC_ADDR_THR_Y, 32'h05);
    wr(tec_pkg::TEC_ADDR_THR_Z, 32'h06);
    rdchk(tec_pkg::TEC_ADDR_THR_Y, 32'h05);
    chk({25'h0, y_tap_threshold}, 32'h05);
    chk({25'h0, z_tap_threshold}, 32'h06);
    sync();
    chk({29'h0, axis_armed}, 32'h7);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 12'h085, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(tec_pkg::TEC_ADDR_SOURCE, 32'hFF);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    wr(tec_pkg::TEC_ADDR_LATENCY, 32'h01);
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h00);
  endtask : t_regs

  task t_gate;
    tap(0, 1'b0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    settle();
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h02);
    tap(0, 1'b1);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    settle();
  endtask : t_gate

  task t_axes;
    logic [31:0] e;
    logic neg;
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h15);
    for (int a = 0; a < 3; a++) begin
      neg = (a != 1);
      e = 32'h80 | (32'h10 << a) | ({31'h0, neg} << a);
      tap(a, neg);
      chk({31'h0, tap_irq}, 32'h1);
      rdchk(tec_pkg::TEC_ADDR_SOURCE, e);
      rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
      sync();
      chk({31'h0, tap_irq}, 32'h0);
      settle();
    end
  endtask : t_axes

  task t_latch;
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h55);
    tap(0, 1'b0);
    settle();
    tap(1, 1'b1);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h90);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    settle();
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h15);
    tap(0, 1'b0);
    settle();
    tap(1, 1'b1);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'hA2);
    settle();
  endtask : t_latch

  // A second tap inside the latency is ignored, so only the tap after it makes a double.
  task t_double;
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h02);
    tap(0, 1'b1);
    tap(0, 1'b1);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    tick();
    tick();
    tap(0, 1'b0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h98);
    settle();
  endtask : t_double

  task t_abort;
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h82);
    tap(0, 1'b0);
    tap(0, 1'b0);
    tick();
    tick();
    tap(0, 1'b0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
    settle();
  endtask : t_abort

  task t_irq;
    wr(tec_pkg::TEC_ADDR_IRQ_CLEAR, 32'h3);
    rdchk(tec_pkg::TEC_ADDR_IRQ_STATUS, 32'h0);
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h01);
    tap(0, 1'b0);
    rdchk(tec_pkg::TEC_ADDR_IRQ_STATUS, 32'h1);
    sync();
    chk({31'h0, irq}, 32'h0);
    wr(tec_pkg::TEC_ADDR_IRQ_ENABLE, 32'h3);
    sync();
    chk({31'h0, irq}, 32'h1);
    wr(tec_pkg::TEC_ADDR_IRQ_CLEAR, 32'h1);
    rdchk(tec_pkg::TEC_ADDR_IRQ_STATUS, 32'h0);
    sync();
    chk({31'h0, irq}, 32'h0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h90);
    settle();
  endtask : t_irq

  task t_disarm;
    wr(tec_pkg::TEC_ADDR_THR_Z, 32'h00);
    sync();
    chk({29'h0, axis_armed}, 32'h3);
    wr(tec_pkg::TEC_ADDR_CONFIG, 32'h10);
    tap(2, 1'b0);
    rdchk(tec_pkg::TEC_ADDR_SOURCE, 32'h0);
  endtask : t_disarm

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_gate();
    t_axes();
    t_latch();
    t_double();
    t_abort();
    t_irq();
    t_disarm();
    results();
  end

  // The whole sequence needs about five hundred cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule : tb
`default_nettype wire
